/* core/sevd_driver.sv */
`timescale 1ns/1ps
// Notes on behaviour
// (R1) seven-stage divider, one backplane per 128 ticks
// (R2) external timebase runs 128 times backplane rate
// (R3) backplane is inverted last stage, 50% duty
// (R4) timebase held low: backplane becomes slaved input
// (R5) external clock low no longer than 1 us
// (R6) 28 segment outputs, seven per digit
// (R7) segment equals backplane, inverted when bit on
// (R8) four shared data bits, four strobes
// (R9) strobe rise latches decoded pattern into digit
// (R10) strobe held high refreshes at backplane edges
// (R11) strobe low holds digit latch unchanged
// (R12) both fonts show 0-9 identically
// (R13) codes 10-15 differ per selected font
// (R14) font chosen at build time only
// (R15) brightness may be duty-cycle modulated externally
// (R16) several strobes high load all selected digits
// (R17) strobes synchronised, latch pulses one cycle
module sevd_driver
  import sevd_pkg::*;
#(
  parameter bit HEX_FONT = 1'b1,
  parameter int EXT_TIMEOUT = sevd_pkg::EXT_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link to the host
  sevd_if.device link,
  // display side
  output logic [sevd_pkg::NUM_DIGITS*sevd_pkg::SEG_BITS-1:0] segments,
  output logic backplane_level,
  output logic slave_mode,
  output logic ext_clock_mode
);
  import sevd_pkg::*;

  localparam int NSYNC = 2 + NUM_DIGITS + BCD_BITS;
  localparam int NSEG = NUM_DIGITS * SEG_BITS;
  // timebase idles high and the backplane leaves reset high
  localparam logic [NSYNC-1:0] SYNC_IDLE = {2'b11, {(NSYNC-2){1'b0}}};

  // the silence counter is only 16 bits wide
  if (EXT_TIMEOUT < 2 || EXT_TIMEOUT > 65535) begin : g_bad_timeout
    $error("EXT_TIMEOUT out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [NSYNC-1:0] pins;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;

  assign pins = {link.timebase_pin, link.bp_wire,
                 link.digit_strobe_fourth, link.digit_strobe_third,
                 link.digit_strobe_second, link.digit_strobe_first,
                 link.bcd_bit_three, link.bcd_bit_two,
                 link.bcd_bit_one, link.bcd_bit_zero};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // idle levels, so no false timebase edge follows reset
      meta_r <= SYNC_IDLE;
      sync_r <= SYNC_IDLE;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r; // [R17]
    end
  end

  logic tb_s;
  logic bp_in_s;
  logic [NUM_DIGITS-1:0] stb_s;
  logic [BCD_BITS-1:0] bcd_s;
  assign {tb_s, bp_in_s, stb_s, bcd_s} = sync_r; // [R8]

  ////////////////////////////////////////////////////////////////////////////
  // oscillator: internal prescaler or external timebase edges
  logic [15:0] osc_cnt_r;
  logic int_tick;
  logic tb_prev_r;
  logic tb_rise;
  logic [15:0] ext_cnt_r;
  logic ext_r;
  logic osc_tick;

  assign int_tick = (osc_cnt_r == 16'(OSC_DIV_CYCLES - 1));
  assign tb_rise = tb_s & ~tb_prev_r;
  assign osc_tick = ext_r ? tb_rise : int_tick; // [R2]

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      osc_cnt_r <= 16'h0000;
    end else if (int_tick) begin
      osc_cnt_r <= 16'h0000;
    end else begin
      osc_cnt_r <= osc_cnt_r + 16'h0001;
    end
  end

  // external mode lasts while edges keep arriving
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tb_prev_r <= 1'b1;
      ext_r <= 1'b0;
      ext_cnt_r <= 16'h0000;
    end else begin
      tb_prev_r <= tb_s;
      if (tb_rise) begin
        ext_r <= 1'b1;
        ext_cnt_r <= 16'h0000;
      end else if (ext_cnt_r == 16'(EXT_TIMEOUT - 1)) begin
        ext_r <= 1'b0;
      end else begin
        ext_cnt_r <= ext_cnt_r + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slave detect: timebase low too long
  logic [7:0] low_cnt_r;
  logic slave_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_cnt_r <= 8'h00;
      slave_r <= 1'b0;
    end else if (tb_s) begin
      low_cnt_r <= 8'h00;
      slave_r <= 1'b0;
    end else if (low_cnt_r == 8'(SLAVE_LOW_CYCLES - 1)) begin
      slave_r <= 1'b1; // [R4] [R5]
    end else begin
      low_cnt_r <= low_cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // backplane divider and driver
  logic [BP_DIV_STAGES-1:0] div_r;
  logic bp_nxt;
  logic bp_r;
  logic bp_toggle;
  logic bp_drive_r;
  logic bp_oe_n_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_r <= '0;
    end else if (osc_tick && !slave_r) begin
      div_r <= div_r + BP_DIV_STAGES'(1); // [R1]
    end
  end

  // slaved backplane is taken from the pin, so no local drift
  assign bp_nxt = slave_r ? bp_in_s : ~div_r[BP_DIV_STAGES-1]; // [R3] [R4]
  assign bp_toggle = (bp_nxt != bp_r);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bp_r <= 1'b1;
      bp_drive_r <= 1'b1;
      bp_oe_n_r <= 1'b0;
    end else begin
      bp_r <= bp_nxt;
      bp_drive_r <= ~div_r[BP_DIV_STAGES-1]; // [R3]
      bp_oe_n_r <= slave_r; // [R4]
    end
  end

  assign link.bp_dev_out = bp_drive_r;
  assign link.bp_dev_oe_n = bp_oe_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // strobe edges, latch pulses and digit latches
  logic [NUM_DIGITS-1:0] stb_prev_r;
  logic [NUM_DIGITS-1:0] latch_pulse;
  logic [SEG_BITS-1:0] decoded;
  logic [NUM_DIGITS-1:0][SEG_BITS-1:0] latch_r;
  logic [NUM_DIGITS-1:0][SEG_BITS-1:0] latch_nxt;

  // font is a parameter: no runtime switch exists
  assign decoded = sevd_decode(bcd_s, HEX_FONT); // [R12] [R13] [R14]

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stb_prev_r <= '0;
    end else begin
      stb_prev_r <= stb_s;
    end
  end

  always_comb begin
    for (int d = 0; d < NUM_DIGITS; d++) begin
      latch_pulse[d] = (stb_s[d] & ~stb_prev_r[d]) // [R9] [R17]
                     | (stb_s[d] & bp_toggle); // [R10]
      latch_nxt[d] = latch_pulse[d] ? decoded : latch_r[d]; // [R11] [R16]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      latch_r <= '0;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // segment drivers follow the backplane that leaves the same edge
  logic [NSEG-1:0] seg_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seg_r <= {NSEG{1'b1}};
    end else begin
      seg_r <= latch_nxt ^ {NSEG{bp_nxt}}; // [R6] [R7]
    end
  end

  assign segments = seg_r;
  assign backplane_level = bp_r;
  assign slave_mode = slave_r;
  assign ext_clock_mode = ext_r;

endmodule : sevd_driver

/* core/sevd_pkg.sv */
package sevd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_FREQ_HZ = 19_000;
  localparam int OSC_DIV_CYCLES = CLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam int BP_DIV_STAGES = 7;
  localparam int SLAVE_LOW_NS = 1000;
  localparam int SLAVE_LOW_CYCLES =
    (SLAVE_LOW_NS / CLK_PERIOD_NS) < 1 ? 1 : SLAVE_LOW_NS / CLK_PERIOD_NS;
  localparam int TB_LOW_MAX_CYCLES = SLAVE_LOW_CYCLES - 1;
  localparam int EXT_TIMEOUT_CYCLES = 8192;
  localparam int STROBE_WIDTH_NS = 1000;
  localparam int STROBE_CYCLES =
    (STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_HOLD_NS = 200;
  localparam int HOLD_CYCLES =
    (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INTER_DIGIT_NS = 2000;
  localparam int GAP_CYCLES =
    (INTER_DIGIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // display shape
  localparam int NUM_DIGITS = 4;
  localparam int SEG_BITS = 7;
  localparam int BCD_BITS = 4;

  // segment bit 0 is a, bit 6 is g
  localparam logic [15:0][6:0] FONT_HEX = {
    7'h71, 7'h79, 7'h5E, 7'h39, 7'h7C, 7'h77,
    7'h6F, 7'h7F, 7'h07, 7'h7D, 7'h6D, 7'h66,
    7'h4F, 7'h5B, 7'h06, 7'h3F};
  localparam logic [15:0][6:0] FONT_CODEB = {
    7'h00, 7'h73, 7'h38, 7'h76, 7'h79, 7'h40,
    7'h6F, 7'h7F, 7'h07, 7'h7D, 7'h6D, 7'h66,
    7'h4F, 7'h5B, 7'h06, 7'h3F};

  function automatic logic [6:0] sevd_decode(input logic [3:0] code,
                                             input logic hex_font);
    sevd_decode = hex_font ? FONT_HEX[code] : FONT_CODEB[code];
  endfunction : sevd_decode

  typedef enum logic [1:0] {
    SEVD_IDLE = 2'b00,
    SEVD_STROBE = 2'b01,
    SEVD_HOLD = 2'b10,
    SEVD_GAP = 2'b11
  } sevd_host_state_t;

endpackage : sevd_pkg

/* core/sevd_if.sv */
`timescale 1ns/1ps
interface sevd_if;
  logic digit_strobe_first;
  logic digit_strobe_second;
  logic digit_strobe_third;
  logic digit_strobe_fourth;
  logic bcd_bit_zero;
  logic bcd_bit_one;
  logic bcd_bit_two;
  logic bcd_bit_three;
  logic timebase_pin;
  logic bp_dev_out;
  logic bp_dev_oe_n;
  logic bp_host_out;
  logic bp_host_oe_n;
  logic bp_wire;

  // undriven backplane reads low
  assign bp_wire = !bp_dev_oe_n ? bp_dev_out :
                   (!bp_host_oe_n ? bp_host_out : 1'b0);

  modport device (
    input digit_strobe_first, digit_strobe_second,
    input digit_strobe_third, digit_strobe_fourth,
    input bcd_bit_zero, bcd_bit_one, bcd_bit_two, bcd_bit_three,
    input timebase_pin, bp_wire,
    output bp_dev_out, bp_dev_oe_n
  );

  modport host (
    output digit_strobe_first, digit_strobe_second,
    output digit_strobe_third, digit_strobe_fourth,
    output bcd_bit_zero, bcd_bit_one, bcd_bit_two, bcd_bit_three,
    output timebase_pin, bp_host_out, bp_host_oe_n,
    input bp_wire
  );
endinterface : sevd_if

/* core/sevd_host.sv */
`timescale 1ns/1ps
module sevd_host
  import sevd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link to the display driver
  sevd_if.host link,
  // digit write requests
  input wire logic wr_valid,
  input wire logic [sevd_pkg::NUM_DIGITS-1:0] wr_mask,
  input wire logic [sevd_pkg::BCD_BITS-1:0] wr_code,
  output logic wr_ready,
  // timebase control
  input wire logic ext_clk_en,
  input wire logic [15:0] ext_half_cycles,
  input wire logic slave_hold,
  // backplane drive for a slaved driver
  input wire logic bp_drive_en,
  input wire logic bp_drive_level
);
  import sevd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // strobe sequencer
  sevd_host_state_t state_r;
  logic [7:0] cnt_r;
  logic [NUM_DIGITS-1:0] stb_r;
  logic [BCD_BITS-1:0] data_r;
  logic ready_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= SEVD_IDLE;
      cnt_r <= 8'h00;
      stb_r <= '0;
      data_r <= '0;
      ready_r <= 1'b1;
    end else begin
      case (state_r)
        SEVD_IDLE: begin
          if (wr_valid && ready_r) begin
            // data and strobes change together, setup may be negative
            stb_r <= wr_mask; // [R8] [R16]
            data_r <= wr_code;
            ready_r <= 1'b0;
            cnt_r <= 8'h00;
            state_r <= SEVD_STROBE;
          end
        end
        SEVD_STROBE: begin
          if (cnt_r == 8'(STROBE_CYCLES - 1)) begin
            stb_r <= '0;
            cnt_r <= 8'h00;
            state_r <= SEVD_HOLD;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        SEVD_HOLD: begin
          if (cnt_r == 8'(HOLD_CYCLES - 1)) begin
            cnt_r <= 8'h00;
            state_r <= SEVD_GAP;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        SEVD_GAP: begin
          if (cnt_r == 8'(GAP_CYCLES - HOLD_CYCLES - 1)) begin
            ready_r <= 1'b1;
            state_r <= SEVD_IDLE;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        default: begin
          state_r <= SEVD_IDLE;
          stb_r <= '0;
          ready_r <= 1'b1;
        end
      endcase
    end
  end

  assign wr_ready = ready_r;
  assign link.digit_strobe_first = stb_r[0];
  assign link.digit_strobe_second = stb_r[1];
  assign link.digit_strobe_third = stb_r[2];
  assign link.digit_strobe_fourth = stb_r[3];
  assign link.bcd_bit_zero = data_r[0];
  assign link.bcd_bit_one = data_r[1];
  assign link.bcd_bit_two = data_r[2];
  assign link.bcd_bit_three = data_r[3];

  ////////////////////////////////////////////////////////////////////////////
  // timebase: idle high, external clock, or held low for slaving
  // low phase is clipped so a slow clock never trips slave mode
  logic [15:0] tb_cnt_r;
  logic tb_r;
  logic [15:0] low_len;

  assign low_len = (ext_half_cycles > 16'(TB_LOW_MAX_CYCLES)) ?
                   16'(TB_LOW_MAX_CYCLES) : ext_half_cycles;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tb_r <= 1'b1;
      tb_cnt_r <= 16'h0000;
    end else if (slave_hold) begin
      tb_r <= 1'b0; // [R4]
      tb_cnt_r <= 16'h0000;
    end else if (!ext_clk_en) begin
      tb_r <= 1'b1;
      tb_cnt_r <= 16'h0000;
    end else if (tb_r) begin
      // high phase fills the rest of the period
      if (tb_cnt_r >= (ext_half_cycles << 1) - low_len - 16'h0001) begin
        tb_r <= 1'b0; // [R2]
        tb_cnt_r <= 16'h0000;
      end else begin
        tb_cnt_r <= tb_cnt_r + 16'h0001;
      end
    end else if (tb_cnt_r >= low_len - 16'h0001) begin
      tb_r <= 1'b1; // [R5]
      tb_cnt_r <= 16'h0000;
    end else begin
      tb_cnt_r <= tb_cnt_r + 16'h0001;
    end
  end

  assign link.timebase_pin = tb_r;

  ////////////////////////////////////////////////////////////////////////////
  // backplane source for a slaved driver
  logic bp_out_r;
  logic bp_oe_n_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bp_out_r <= 1'b0;
      bp_oe_n_r <= 1'b1;
    end else begin
      bp_out_r <= bp_drive_level;
      bp_oe_n_r <= ~bp_drive_en;
    end
  end

  assign link.bp_host_out = bp_out_r;
  assign link.bp_host_oe_n = bp_oe_n_r;

endmodule : sevd_host

/* testbench/sevd_chk.sv */
`timescale 1ns/1ps
module sevd_chk (
  // clock and reset
  input logic clk,
  input logic reset,
  // link signals
  input logic digit_strobe_first,
  input logic bcd_bit_zero,
  input logic bcd_bit_one,
  input logic bcd_bit_two,
  input logic bcd_bit_three,
  input logic timebase_pin,
  input logic bp_dev_out,
  input logic bp_dev_oe_n,
  input logic bp_host_oe_n
);
  logic tb_q_r;
  logic bp_q_r;
  logic seen_r;
  logic [7:0] rises_r;
  logic [4:0] low_r;
  logic [3:0] bcd;
  logic toggle;

  assign bcd = {bcd_bit_three, bcd_bit_two, bcd_bit_one, bcd_bit_zero};
  assign toggle = bp_dev_out != bp_q_r;

  ////////////////////////////////////////////////////////////////////////////
  // ticks between backplane edges; first edge after a slave spell is
  // skipped since the divider phase is then unknown
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tb_q_r <= 1'b1;
      bp_q_r <= 1'b1;
      rises_r <= 8'h00;
      seen_r <= 1'b0;
    end else begin
      tb_q_r <= timebase_pin;
      bp_q_r <= bp_dev_out;
      if (toggle) begin
        rises_r <= 8'h00;
        seen_r <= !bp_dev_oe_n;
      end else if (timebase_pin && !tb_q_r) begin
        rises_r <= rises_r + 8'h01;
      end
      if (bp_dev_oe_n) begin
        seen_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_r <= 5'h00;
    end else if (timebase_pin) begin
      low_r <= 5'h00;
    end else if (low_r != 5'h1F) begin
      low_r <= low_r + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_strobe_width;
    $rose(digit_strobe_first) |-> digit_strobe_first[*8] ##1
      digit_strobe_first[*2] ##1 !digit_strobe_first;
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("strobe width wrong");

  property p_bcd_stable;
    digit_strobe_first && $past(digit_strobe_first) |-> $stable(bcd);
  endproperty
  a_bcd_stable: assert property (p_bcd_stable)
    else $error("data moved under strobe");

  property p_data_hold;
    $fell(digit_strobe_first) |-> $stable(bcd)[*2];
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data hold too short");

  property p_slave_enter;
    low_r == 5'h10 |-> bp_dev_oe_n;
  endproperty
  a_slave_enter: assert property (p_slave_enter)
    else $error("backplane still driven");

  property p_slave_leave;
    timebase_pin[*8] |-> !bp_dev_oe_n;
  endproperty
  a_slave_leave: assert property (p_slave_leave)
    else $error("backplane not driven");

  property p_no_fight;
    !(!bp_dev_oe_n && !bp_host_oe_n);
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("backplane contention");

  property p_period;
    toggle && seen_r |-> rises_r == 8'h40;
  endproperty
  a_period: assert property (p_period)
    else $error("backplane half period wrong");

  property p_bp_stable;
    toggle && !bp_dev_oe_n |=> $stable(bp_dev_out)[*8];
  endproperty
  a_bp_stable: assert property (p_bp_stable)
    else $error("backplane glitch");
endmodule : sevd_chk

/* testbench/sevd_tb_top.sv */
`timescale 1ns/1ps
module sevd_tb_top;
  import sevd_pkg::*;
  localparam logic [6:0] HEXF [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
    7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79,
    7'h71};
  localparam logic [6:0] CBF [6] = '{7'h40, 7'h79, 7'h76, 7'h38, 7'h73,
    7'h00};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wr_valid = 1'b0;
  logic [3:0] wr_mask = 4'h0;
  logic [3:0] wr_code = 4'h0;
  logic ext_clk_en = 1'b0;
  logic slave_hold = 1'b0;
  logic bp_drive_en = 1'b0;
  logic bp_drive_level = 1'b0;
  logic [15:0] half_cycles = 16'h0004;
  logic wr_ready;
  logic bp_lvl;
  logic bp_lvl_b;
  logic slave_mode;
  logic ext_mode;
  logic [27:0] segs;
  logic [27:0] segs_b;
  logic [6:0] mh [4];
  logic [6:0] mc [4];
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;

  sevd_if link ();
  sevd_if link_b ();

  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // the code B copy shares all host inputs so both fonts see one stream
  sevd_host sevd_host_inst (.clk(clk), .reset(reset), .link(link),
    .wr_valid(wr_valid), .wr_mask(wr_mask), .wr_code(wr_code),
    .wr_ready(wr_ready), .ext_clk_en(ext_clk_en),
    .ext_half_cycles(half_cycles), .slave_hold(slave_hold),
    .bp_drive_en(bp_drive_en), .bp_drive_level(bp_drive_level));
  sevd_driver #(.HEX_FONT(1'b1), .EXT_TIMEOUT(64)) sevd_driver_inst (
    .clk(clk), .reset(reset), .link(link), .segments(segs),
    .backplane_level(bp_lvl), .slave_mode(slave_mode),
    .ext_clock_mode(ext_mode));
  sevd_host sevd_host_b_inst (.clk(clk), .reset(reset), .link(link_b),
    .wr_valid(wr_valid), .wr_mask(wr_mask), .wr_code(wr_code),
    .wr_ready(), .ext_clk_en(ext_clk_en),
    .ext_half_cycles(half_cycles), .slave_hold(slave_hold),
    .bp_drive_en(bp_drive_en), .bp_drive_level(bp_drive_level));
  sevd_driver #(.HEX_FONT(1'b0), .EXT_TIMEOUT(64)) sevd_driver_b_inst (
    .clk(clk), .reset(reset), .link(link_b), .segments(segs_b),
    .backplane_level(bp_lvl_b), .slave_mode(), .ext_clock_mode());
  sevd_chk sevd_chk_inst (.clk(clk), .reset(reset),
    .digit_strobe_first(link.digit_strobe_first),
    .bcd_bit_zero(link.bcd_bit_zero), .bcd_bit_one(link.bcd_bit_one),
    .bcd_bit_two(link.bcd_bit_two), .bcd_bit_three(link.bcd_bit_three),
    .timebase_pin(link.timebase_pin), .bp_dev_out(link.bp_dev_out),
    .bp_dev_oe_n(link.bp_dev_oe_n), .bp_host_oe_n(link.bp_host_oe_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [27:0] got, input logic [27:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [27:0] pack(input logic bp,
                                       input logic [6:0] m [4]);
    for (int d = 0; d < 4; d++) begin
      pack[7*d +: 7] = m[d] ^ {7{bp}};
    end
  endfunction : pack

  task automatic wr(input logic [3:0] mask, input logic [3:0] code);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (wr_ready !== 1'b1 && n < 100);
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_mask <= mask;
    wr_code <= code;
    @(posedge clk);
    wr_valid <= 1'b0;
    for (int d = 0; d < 4; d++) begin
      if (mask[d]) begin
        mh[d] = HEXF[code];
        mc[d] = code > 4'h9 ? CBF[code - 4'hA] : HEXF[code];
      end
    end
    repeat (8) @(posedge clk);
    @(negedge clk);
    check(segs, pack(bp_lvl, mh));
    check(segs_b, pack(bp_lvl_b, mc));
  endtask : wr

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  // a hang costs a mismatch rather than a silent stall
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    logic bp_was;
    for (int d = 0; d < 4; d++) begin
      mh[d] = 7'h00;
      mc[d] = 7'h00;
    end
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    ext_clk_en <= 1'b1;
    @(negedge clk);
    check(segs, pack(bp_lvl, mh));
    for (int c = 0; c < 16; c++) begin
      wr(4'hF, c[3:0]);
    end
    wr(4'h1, 4'h1);
    wr(4'h2, 4'h2);
    wr(4'h4, 4'h3);
    wr(4'h8, 4'h4);
    wr(4'h2, 4'h5);
    n = 0;
    bp_was = bp_lvl;
    while (bp_lvl === bp_was && n < 1200) begin
      @(negedge clk);
      n++;
    end
    check({27'h0, bp_lvl}, {27'h0, ~bp_was});
    check(segs, pack(bp_lvl, mh));
    check({27'h0, ext_mode}, 28'h1);
    // a long half period must be clipped so the driver stays master
    @(posedge clk);
    half_cycles <= 16'h000C;
    repeat (100) @(posedge clk);
    @(negedge clk);
    check({27'h0, slave_mode}, 28'h0);
    // host may only drive once the device has let go of the wire
    @(posedge clk);
    slave_hold <= 1'b1;
    repeat (20) @(posedge clk);
    bp_drive_en <= 1'b1;
    bp_drive_level <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check({27'h0, slave_mode}, 28'h1);
    check(segs, pack(1'b0, mh));
    @(posedge clk);
    bp_drive_level <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(segs, pack(1'b1, mh));
    @(posedge clk);
    bp_drive_en <= 1'b0;
    repeat (3) @(posedge clk);
    slave_hold <= 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    check({27'h0, slave_mode}, 28'h0);
    // with the clock stopped the driver falls back to its own timebase
    @(posedge clk);
    ext_clk_en <= 1'b0;
    repeat (80) @(posedge clk);
    @(negedge clk);
    check({27'h0, ext_mode}, 28'h0);
    check(segs, pack(bp_lvl, mh));
    conclude();
  end
endmodule : sevd_tb_top
